// >>> dbif_pkg.sv
// Constants, carriers and state layout for the dual-bank interrupt flag block.
// Assumes an APB host with 16-bit byte addresses; each register is one aligned word.
package dbif_pkg;

  // Register indices; byte address is four times the index
  localparam logic [13:0] IDX_B1_BOOT = 14'h0d04;
  localparam logic [13:0] IDX_B1_SHORT = 14'h0d05;
  localparam logic [13:0] IDX_MASK_FIRST = 14'h0d08;
  localparam logic [13:0] IDX_MASK_LAST = 14'h0d0d;
  localparam logic [13:0] IDX_INTERRUPT_OUTPUT_ONE_CTRL = 14'h0d0f;
  localparam logic [13:0] IDX_B2_GPIO = 14'h0d10;
  localparam logic [13:0] IDX_B2_DSP = 14'h0d11;
  localparam logic [13:0] IDX_B2_SPK = 14'h0d12;
  localparam logic [13:0] IDX_AOD_FLAGS = 14'h0d51;
  localparam logic [13:0] IDX_AOD_MASKS = 14'h0d53;
  localparam int unsigned MASK_WORDS = 6;
  localparam int unsigned MASK_BOOT_WORD = 4;
  localparam int unsigned MASK_SHORT_WORD = 5;

  // Field positions
  localparam int unsigned BIT_BOOT = 8;
  localparam int unsigned BIT_MIC_FALL = 7;
  localparam int unsigned BIT_MIC_RISE = 6;
  localparam int unsigned BIT_P5_FALL = 5;
  localparam int unsigned BIT_P5_RISE = 4;
  localparam int unsigned BIT_JD_FALL = 3;
  localparam int unsigned BIT_JD_RISE = 2;
  localparam int unsigned BIT_SPK_WARN = 15;
  localparam int unsigned BIT_SPK_HOT = 14;
  localparam int unsigned BIT_GMASK = 0;

  // Implemented bits of each word
  localparam logic [15:0] VALID_BOOT = 16'h0100;
  localparam logic [15:0] VALID_SHORT = 16'h003f;
  localparam logic [15:0] VALID_AOD = 16'h00fc;
  localparam logic [15:0] VALID_GPIO = 16'h000f;
  localparam logic [15:0] VALID_DSP = 16'h0fff;
  localparam logic [15:0] VALID_SPK = 16'hc000;

  // Values after reset
  localparam logic [15:0] RST_MASK = 16'hffff;
  localparam logic [15:0] RST_MASK_BOOT = 16'hfeff;
  localparam logic [15:0] RST_AOD_MASK = 16'hffff;
  localparam logic RST_GMASK = 1'b0;
  localparam logic [1:0] PRIME_CYCLES = 2'h3;

  // Event sources, one bit each
  typedef struct packed {
    logic [5:0] hp_short;
    logic boot_done;
    logic mic_clamp;
    logic pin5;
    logic jack_detect;
    logic [3:0] gpio;
    logic [3:0] ram_ready;
    logic [7:0] soft_irq;
    logic spk_hot_warn;
    logic spk_hot;
  } dbif_src_s;

  localparam int unsigned SRC_W = $bits(dbif_src_s);

  typedef struct packed {
    dbif_src_s sync1;
    dbif_src_s sync2;
    dbif_src_s sync3;
    dbif_src_s level;
    logic [1:0] prime;
    logic [15:0] b1_boot;
    logic [15:0] b1_short;
    logic [MASK_WORDS-1:0][15:0] mask;
    logic gmask;
    logic [15:0] aod;
    logic [15:0] aod_mask;
    logic [15:0] b2_gpio;
    logic [15:0] b2_dsp;
    logic [15:0] b2_spk;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic interrupt_output_one;
    logic interrupt_output_two;
  } dbif_state_s;

endpackage

// >>> dbif_top.sv
// Interrupt flag tail of bank one, its masks and global output mask, the
// always-on flags and masks, and the first three status words of bank two.
// Assumes an APB4 master on i_clk and sources that may be asynchronous.
//
// Notes on behaviour
// - A latched flag stays set until software writes a one to its bit, which clears it.
// - Six headphone short flags, positive and negative per channel, latch on rising edge.
// - Each bank one flag has a mask bit; 0 passes it to output one, 1 blocks it.
// - After reset the boot complete mask bit is 0 and every other bank one mask bit is 1.
// - Bit 0 of the control word masks output one globally, reset 0, 1 holds it low.
// - Always-on word latches fall and rise flags for mic clamp, pin five and jack detect.
// - Each always-on flag has a mask bit that resets to 1; 0 unmasks it.
// - Bank two word one latches a both-edge flag for each of pins one to four.
// - Bank two word two latches a rising-edge ram ready flag per core in bits 8 to 11.
// - The same word latches eight both-edge core soft interrupt flags in bits 0 to 7.
// - Bank two word three latches both-edge speaker hot warning and hot flags.

`timescale 1ns/100ps

module dbif_top
  import dbif_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [15:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  output logic o_pready,
  output logic [31:0] o_prdata,
  output logic o_pslverr,
  // Event sources
  input wire dbif_src_s i_src,
  // Interrupt outputs
  output logic o_interrupt_output_one,
  output logic o_interrupt_output_two
);

  dbif_state_s st;
  dbif_state_s next_st;

  function automatic logic [15:0] lane_mask(input logic [3:0] strb);
    lane_mask = {{8{strb[1]}}, {8{strb[0]}}};
  endfunction

  // Set wins over a clear in the same cycle
  function automatic logic [15:0] w1c(input logic [15:0] old, input logic [15:0] clr,
                                      input logic [15:0] set, input logic [15:0] valid);
    w1c = ((old & ~clr) | set) & valid;
  endfunction

  function automatic logic [15:0] rw16(input logic [15:0] old, input logic [15:0] data,
                                       input logic [15:0] lanes);
    rw16 = (old & ~lanes) | (data & lanes);
  endfunction

  function automatic logic is_mask_idx(input logic [13:0] idx);
    is_mask_idx = (idx >= IDX_MASK_FIRST) && (idx <= IDX_MASK_LAST);
  endfunction

  function automatic logic is_mapped(input logic [13:0] idx);
    is_mapped = is_mask_idx(idx) || (idx == IDX_B1_BOOT) || (idx == IDX_B1_SHORT) ||
                (idx == IDX_INTERRUPT_OUTPUT_ONE_CTRL) || (idx == IDX_B2_GPIO) || (idx == IDX_B2_DSP) ||
                (idx == IDX_B2_SPK) || (idx == IDX_AOD_FLAGS) || (idx == IDX_AOD_MASKS);
  endfunction

  function automatic logic [15:0] read_word(input dbif_state_s s, input logic [13:0] idx);
    logic [2:0] k;
    k = 3'(idx - IDX_MASK_FIRST);
    read_word = 16'h0000;
    if (is_mask_idx(idx)) begin
      read_word = s.mask[k];
    end else begin
      case (idx)
        IDX_B1_BOOT: read_word = s.b1_boot;
        IDX_B1_SHORT: read_word = s.b1_short;
        IDX_INTERRUPT_OUTPUT_ONE_CTRL: read_word = {15'h0000, s.gmask};
        IDX_B2_GPIO: read_word = s.b2_gpio;
        IDX_B2_DSP: read_word = s.b2_dsp;
        IDX_B2_SPK: read_word = s.b2_spk;
        IDX_AOD_FLAGS: read_word = s.aod;
        IDX_AOD_MASKS: read_word = s.aod_mask;
        default: read_word = 16'h0000;
      endcase
    end
  endfunction

  function automatic dbif_state_s reset_state();
    dbif_state_s r;
    r = '0;
    for (int k = 0; k < MASK_WORDS; k++) begin
      r.mask[k] = RST_MASK;
    end
    r.mask[MASK_BOOT_WORD] = RST_MASK_BOOT;
    r.gmask = RST_GMASK;
    r.aod_mask = RST_AOD_MASK;
    reset_state = r;
  endfunction

  always_comb begin
    logic [SRC_W-1:0] s2_v;
    logic [SRC_W-1:0] s3_v;
    logic [SRC_W-1:0] lvl_v;
    logic [SRC_W-1:0] new_v;
    logic [SRC_W-1:0] agree_v;
    logic primed;
    dbif_src_s rise;
    dbif_src_s fall;
    dbif_src_s both;
    logic [13:0] idx;
    logic aligned;
    logic setup;
    logic access;
    logic wr;
    logic [15:0] lanes;
    logic [15:0] wdata;
    logic [15:0] wbits;
    logic [15:0] set_boot;
    logic [15:0] set_short;
    logic [15:0] set_aod;
    logic [15:0] set_gpio;
    logic [15:0] set_dsp;
    logic [15:0] set_spk;
    logic pending;

    // Defaults for every local, so no path leaves one unassigned
    s2_v = '0;
    s3_v = '0;
    lvl_v = '0;
    new_v = '0;
    agree_v = '0;
    primed = 1'b0;
    rise = '0;
    fall = '0;
    both = '0;
    idx = '0;
    aligned = 1'b0;
    setup = 1'b0;
    access = 1'b0;
    wr = 1'b0;
    lanes = '0;
    wdata = '0;
    wbits = '0;
    set_boot = '0;
    set_short = '0;
    set_aod = '0;
    set_gpio = '0;
    set_dsp = '0;
    set_spk = '0;
    pending = 1'b0;

    next_st = st;

    // Sampling chain; the first stage feeds only the second
    next_st.sync1 = i_src;
    next_st.sync2 = st.sync1;
    next_st.sync3 = st.sync2;

    // A change counts once the second and third stages agree
    s2_v = st.sync2;
    s3_v = st.sync3;
    lvl_v = st.level;
    agree_v = ~(s2_v ^ s3_v);
    new_v = (s3_v & agree_v) | (lvl_v & ~agree_v);

    // Until the chain has filled, adopt the level without raising edges;
    // the second stage is the one that holds the live level at the last
    // priming edge, so a source already high after reset raises no edge
    primed = (st.prime == PRIME_CYCLES);
    if (!primed) begin
      next_st.prime = st.prime + 2'h1;
      next_st.level = dbif_src_s'(s2_v);
      rise = '0;
      fall = '0;
    end else begin
      next_st.level = dbif_src_s'(new_v);
      rise = dbif_src_s'(new_v & ~lvl_v);
      fall = dbif_src_s'(~new_v & lvl_v);
    end
    both = dbif_src_s'(SRC_W'(rise) | SRC_W'(fall));

    // Flag set vectors, independent of any mask
    set_boot = 16'h0000;
    set_boot[BIT_BOOT] = rise.boot_done;
    set_short = {10'h000, rise.hp_short};
    set_aod = 16'h0000;
    set_aod[BIT_MIC_FALL] = fall.mic_clamp;
    set_aod[BIT_MIC_RISE] = rise.mic_clamp;
    set_aod[BIT_P5_FALL] = fall.pin5;
    set_aod[BIT_P5_RISE] = rise.pin5;
    set_aod[BIT_JD_FALL] = fall.jack_detect;
    set_aod[BIT_JD_RISE] = rise.jack_detect;
    set_gpio = {12'h000, both.gpio};
    set_dsp = {4'h0, rise.ram_ready, both.soft_irq};
    set_spk = 16'h0000;
    set_spk[BIT_SPK_WARN] = both.spk_hot_warn;
    set_spk[BIT_SPK_HOT] = both.spk_hot;

    // APB: setup loads the answer, the following access completes it
    idx = i_paddr[15:2];
    aligned = (i_paddr[1:0] == 2'b00);
    setup = i_psel && !i_penable && !st.pready;
    access = i_psel && i_penable && st.pready;
    wr = access && i_pwrite && aligned;
    lanes = lane_mask(i_pstrb);
    wdata = i_pwdata[15:0];
    wbits = wdata & lanes;

    if (setup) begin
      next_st.pready = 1'b1;
      next_st.pslverr = !aligned || !is_mapped(idx);
      next_st.prdata = 32'h00000000;
      if (aligned && !i_pwrite) begin
        next_st.prdata = {16'h0000, read_word(st, idx)};
      end
    end else if (access) begin
      next_st.pready = 1'b0;
      next_st.pslverr = 1'b0;
    end

    // Write-one-to-clear status words
    next_st.b1_boot = w1c(st.b1_boot, (wr && idx == IDX_B1_BOOT) ? wbits : 16'h0000,
                          set_boot, VALID_BOOT);
    next_st.b1_short = w1c(st.b1_short, (wr && idx == IDX_B1_SHORT) ? wbits : 16'h0000,
                           set_short, VALID_SHORT);
    next_st.aod = w1c(st.aod, (wr && idx == IDX_AOD_FLAGS) ? wbits : 16'h0000,
                      set_aod, VALID_AOD);
    next_st.b2_gpio = w1c(st.b2_gpio, (wr && idx == IDX_B2_GPIO) ? wbits : 16'h0000,
                          set_gpio, VALID_GPIO);
    next_st.b2_dsp = w1c(st.b2_dsp, (wr && idx == IDX_B2_DSP) ? wbits : 16'h0000,
                         set_dsp, VALID_DSP);
    next_st.b2_spk = w1c(st.b2_spk, (wr && idx == IDX_B2_SPK) ? wbits : 16'h0000,
                         set_spk, VALID_SPK);

    // Mask and control words
    for (int k = 0; k < MASK_WORDS; k++) begin
      if (wr && idx == IDX_MASK_FIRST + 14'(k)) begin
        next_st.mask[k] = rw16(st.mask[k], wdata, lanes);
      end
    end
    if (wr && idx == IDX_INTERRUPT_OUTPUT_ONE_CTRL && i_pstrb[0]) begin
      next_st.gmask = wdata[BIT_GMASK];
    end
    if (wr && idx == IDX_AOD_MASKS) begin
      next_st.aod_mask = rw16(st.aod_mask, wdata, lanes);
    end

    // Output one follows the flags of the same cycle
    pending = |(next_st.b1_boot & ~next_st.mask[MASK_BOOT_WORD]) ||
              |(next_st.b1_short & ~next_st.mask[MASK_SHORT_WORD]) ||
              |(next_st.aod & ~next_st.aod_mask);
    next_st.interrupt_output_one = pending && !next_st.gmask;
    // Bank two masks live elsewhere; this is the raw request
    next_st.interrupt_output_two = |(next_st.b2_gpio | next_st.b2_dsp | next_st.b2_spk);

    if (i_rst) begin
      next_st = reset_state();
    end
  end

  always_ff @(posedge i_clk) begin
    st <= next_st;
  end

  assign o_pready = st.pready;
  assign o_prdata = st.prdata;
  assign o_pslverr = st.pslverr;
  assign o_interrupt_output_one = st.interrupt_output_one;
  assign o_interrupt_output_two = st.interrupt_output_two;

endmodule

// >>> dbif_src_model.sv
// Source model: device-side levels that feed the flag block.
// Assumes the bench sets next levels; changes land on a rising edge.
`timescale 1ns/100ps
module dbif_src_model
  import dbif_pkg::*;
(
  // Clock
  input wire logic i_clk,
  // Levels asked for and presented
  input wire dbif_src_s i_next,
  output dbif_src_s o_src
);
  always_ff @(posedge i_clk) begin
    o_src <= i_next;
  end
endmodule

// >>> dbif_top_assertions.sv
// Port checker for dbif_top, bound below.
// Assumes sources are held several cycles between changes.
`timescale 1ns/100ps
module dbif_checker
  import dbif_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [15:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  input wire logic o_pready,
  input wire logic [31:0] o_prdata,
  input wire logic o_pslverr,
  input wire dbif_src_s i_src,
  input wire logic o_interrupt_output_one,
  input wire logic o_interrupt_output_two
);
  logic gm;
  logic [2:0] up;
  // Edge checks wait until the sampling chain has filled
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      gm <= 1'b0;
      up <= 3'h0;
    end else begin
      if (up != 3'h7) up <= up + 3'h1;
      if (i_psel && i_penable && o_pready && i_pwrite && i_pstrb[0] &&
          i_paddr == {IDX_INTERRUPT_OUTPUT_ONE_CTRL, 2'b00}) gm <= i_pwdata[0];
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  reset_quiet_a: assert property ($fell(i_rst) |-> !o_interrupt_output_one && !o_interrupt_output_two && !o_pready)
    else $error("output active after reset");
  gmask_hold_a: assert property (gm |-> !o_interrupt_output_one)
    else $error("output one not held by global mask");
  setup_answer_a: assert property (i_psel && !i_penable && !o_pready |=> o_pready)
    else $error("no ready after setup");
  ready_pulse_a: assert property (o_pready |=> !o_pready)
    else $error("ready longer than one cycle");
  misalign_err_a: assert property (i_psel && !i_penable && !o_pready && i_paddr[1:0] != 2'b00
    |=> o_pslverr) else $error("misaligned access not refused");
  err_ready_a: assert property (o_pslverr |-> o_pready)
    else $error("error without ready");
  gpio_edge_a: assert property (up == 3'h7 && $changed(i_src.gpio) |-> ##[3:6] o_interrupt_output_two)
    else $error("pin edge not flagged");
  soft_edge_a: assert property (up == 3'h7 && $changed(i_src.soft_irq) |-> ##[3:6] o_interrupt_output_two)
    else $error("soft interrupt edge not flagged");
  spk_edge_a: assert property (
    up == 3'h7 && $changed({i_src.spk_hot_warn, i_src.spk_hot}) |-> ##[3:6] o_interrupt_output_two)
    else $error("speaker edge not flagged");
  ram_rise_a: assert property (
    up == 3'h7 && |(i_src.ram_ready & ~$past(i_src.ram_ready)) |-> ##[3:6] o_interrupt_output_two)
    else $error("ram ready rise not flagged");
  cover property ($rose(o_interrupt_output_one));
  cover property (o_pslverr);
  cover property (gm && up == 3'h7);
endmodule
bind dbif_top dbif_checker u_chk(.i_clk(i_clk), .i_rst(i_rst), .i_psel(i_psel),
  .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
  .i_pstrb(i_pstrb), .o_pready(o_pready), .o_prdata(o_prdata), .o_pslverr(o_pslverr),
  .i_src(i_src), .o_interrupt_output_one(o_interrupt_output_one), .o_interrupt_output_two(o_interrupt_output_two));

// >>> testbench.sv
// Self-checking bench: register resets, flag latch and clear, mask gating.
// Assumes the source model adds one cycle before levels reach the block.
`timescale 1ns/100ps
module testbench
  import dbif_pkg::*;
;
  logic i_clk, i_rst, i_psel, i_penable, i_pwrite, o_pready, o_pslverr, o_interrupt_output_one, o_interrupt_output_two;
  logic [15:0] i_paddr, m0c, m0d, am, cl;
  logic [31:0] i_pwdata, o_prdata, rd;
  logic [3:0] i_pstrb;
  dbif_src_s nxt, src, cur, r, f, c;
  logic [15:0] e [6];
  logic [13:0] fi [6];
  logic gm, err;
  int n_mismatch = 0, n_checks = 0, cyc = 0, k, j;
  integer seed;
  dbif_src_model u_src(.i_clk(i_clk), .i_next(nxt), .o_src(src));
  dbif_top u_dut(.i_clk(i_clk), .i_rst(i_rst), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .i_pstrb(i_pstrb),
    .o_pready(o_pready), .o_prdata(o_prdata), .o_pslverr(o_pslverr), .i_src(src),
    .o_interrupt_output_one(o_interrupt_output_one), .o_interrupt_output_two(o_interrupt_output_two));
  task give_verdict();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      $display("Error %0t: saw %h expected %h", $time, seen, exp);
      n_mismatch++;
    end
  endtask
  function logic [15:0] ad(input logic [13:0] i);
    return {i, 2'b00};
  endfunction
  // Read compares data with d; both directions compare the error flag
  task apb(input logic w, input logic [15:0] a, input logic [15:0] d, input logic ee);
    int t;
    @(posedge i_clk);
    i_psel <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= {16'h0, d};
    @(posedge i_clk);
    i_penable <= 1'b1;
    t = 0;
    // Answer read at the completing edge, before the design updates
    do begin
      @(posedge i_clk);
      t++;
    end while (o_pready !== 1'b1 && t < 16);
    rd = o_prdata;
    err = o_pslverr;
    if (o_pready !== 1'b1) n_mismatch++;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
    if (!w) check(rd, {16'h0, d});
    check(32'(err), 32'(ee));
  endtask
  task apply(input dbif_src_s n);
    r = n & ~cur;
    f = cur & ~n;
    c = n ^ cur;
    e[0][BIT_BOOT] |= r.boot_done;
    e[1] |= {10'h0, r.hp_short};
    e[2] |= {8'h0, f.mic_clamp, r.mic_clamp, f.pin5, r.pin5, f.jack_detect, r.jack_detect,
      2'b00};
    e[3] |= {12'h0, c.gpio};
    e[4] |= {4'h0, r.ram_ready, c.soft_irq};
    e[5] |= {c.spk_hot_warn, c.spk_hot, 14'h0};
    cur = n;
    nxt <= n;
    repeat (10) @(posedge i_clk);
  endtask
  task irqs();
    repeat (2) @(negedge i_clk);
    check(32'(o_interrupt_output_one), 32'(!gm && |((e[0] & ~m0c) | (e[1] & ~m0d) | (e[2] & ~am))));
    check(32'(o_interrupt_output_two), 32'(|(e[3] | e[4] | e[5])));
  endtask
  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      give_verdict();
    end
  end
  initial begin
    seed = 32'h687aa149;
    {i_rst, i_psel, i_penable, i_pwrite, i_paddr, i_pwdata, i_pstrb} = {1'b1, 51'h0, 4'h3};
    nxt = '0;
    cur = '0;
    e = '{default: 16'h0};
    fi = '{IDX_B1_BOOT, IDX_B1_SHORT, IDX_AOD_FLAGS, IDX_B2_GPIO, IDX_B2_DSP, IDX_B2_SPK};
    {gm, m0c, m0d, am} = {RST_GMASK, RST_MASK_BOOT, RST_MASK, RST_AOD_MASK};
    repeat (4) @(posedge i_clk);
    i_rst <= 1'b0;
    repeat (6) @(posedge i_clk);
    for (k = 0; k < 6; k++) begin
      apb(1'b0, ad(IDX_MASK_FIRST + 14'(k)), (k == 4) ? RST_MASK_BOOT : RST_MASK, 1'b0);
    end
    apb(1'b0, ad(IDX_INTERRUPT_OUTPUT_ONE_CTRL), 16'h0, 1'b0);
    apb(1'b0, ad(IDX_AOD_MASKS), RST_AOD_MASK, 1'b0);
    apb(1'b0, ad(14'h0d0e), 16'h0, 1'b1);
    apb(1'b1, 16'h3441, 16'hffff, 1'b1);
    for (k = 0; k < 40; k++) begin
      // First round: boot alone, unmasked from reset
      if (k == 0) begin
        r = '0;
        r.boot_done = 1'b1;
        apply(r);
      end else apply(dbif_src_s'(SRC_W'($random(seed))));
      if (k > 0) begin
        {m0c, m0d, am, gm} = 49'($random(seed) * $random(seed));
        apb(1'b1, ad(IDX_MASK_LAST - 14'h1), m0c, 1'b0);
        apb(1'b1, ad(IDX_MASK_LAST), m0d, 1'b0);
        apb(1'b1, ad(IDX_AOD_MASKS), am, 1'b0);
        apb(1'b1, ad(IDX_INTERRUPT_OUTPUT_ONE_CTRL), {15'h0, gm}, 1'b0);
        apb(1'b0, ad(IDX_MASK_LAST), m0d, 1'b0);
      end
      irqs();
      for (j = 0; j < 6; j++) begin
        apb(1'b0, ad(fi[j]), e[j], 1'b0);
        cl = 16'($random(seed));
        apb(1'b1, ad(fi[j]), cl, 1'b0);
        e[j] &= ~cl;
      end
      irqs();
    end
    give_verdict();
  end
endmodule
